// >>> verilog/pde_pkg.sv
/*
 * Shared constants for the PCI/memory DMA engine: register offsets,
 * control field positions, reset values, FIFO sizing and engine states.
 * Assumes an AXI4-Lite register port with 8-bit byte addresses.
 */
package pde_pkg;

  // Sizing
  localparam int NCH = 4;
  localparam int FIFO_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CW = 4;
  localparam logic [3:0] HALF_WORDS = 4'h4;
  localparam int ADDR_W = 8;
  localparam int WORDS_W = 19;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [NCH-1:0][7:0] OFF_CTRL = {8'hB0, 8'hA4, 8'h44, 8'h38};
  localparam logic [7:0] OFF_MADDR_REL = 8'h04;
  localparam logic [7:0] OFF_PADDR_REL = 8'h08;
  localparam logic [7:0] OFF_WREM = 8'h64;
  localparam logic [7:0] OFF_CMEM = 8'h68;
  localparam logic [7:0] OFF_CPCI = 8'h6C;
  localparam logic [7:0] OFF_PRIO = 8'h80;
  localparam logic [7:0] OFF_NRA = 8'h90;
  localparam logic [7:0] OFF_ISR = 8'h94;
  localparam logic [7:0] OFF_BES = 8'h98;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int B_SIZE_MSB = 19;
  localparam int B_DRST = 24;
  localparam int B_MIO = 25;
  localparam int B_INC = 26;
  localparam int B_GO = 28;
  localparam int B_DIR = 29;
  localparam int B_IE = 30;
  localparam int B_BUSY = 31;
  localparam int B_BERR = 5;
  localparam int CHAIN_LSB = 8;
  localparam int PRIO_W = 14;
  localparam logic [NCH-1:0][4:0] DONE_BIT = {5'h11, 5'h10, 5'h02, 5'h01};

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and answers
  localparam logic [PRIO_W-1:0] PRIO_RST = 14'h0009;
  localparam logic [WORDS_W-1:0] WORDS_1MB = 19'h40000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Engine states
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_XFER, S_YIELD} pde_state_t;

endpackage : pde_pkg

// >>> verilog/pde_fifo.sv
/*
 * Bidirectional DMA data FIFO, one write port and one read port.
 * Assumes a power-of-two depth and a caller that never pushes when full
 * or pops when empty; such requests are ignored.
 */
`timescale 1ns/1ns
module pde_fifo #(
  parameter int W = pde_pkg::FIFO_W,
  parameter int D = pde_pkg::FIFO_DEPTH,
  parameter int CW = pde_pkg::FIFO_CW
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] rdata,
  // Level
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  import pde_pkg::*;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-2:0] wp;
    logic [CW-2:0] rp;
    logic [CW-1:0] cnt;
  } pde_fifo_t;

  pde_fifo_t s;
  pde_fifo_t next_s;
  logic pu;
  logic po;

  assign full = (s.cnt == CW'(D));
  assign empty = (s.cnt == '0);
  assign count = s.cnt;
  assign rdata = s.mem[s.rp];
  assign pu = push && !full;
  assign po = pop && !empty;

  always_comb begin
    next_s = s;
    if (clr) begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end else begin
      if (pu) begin
        next_s.mem[s.wp] = wdata;
        next_s.wp = s.wp + 1'b1;
      end
      if (po) begin
        next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + CW'(pu) - CW'(po);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : pde_fifo

// >>> verilog/pde_engine.sv
/*
 * DMA engine between local memory and the PCI bus, with four register
 * sets, descriptor chaining and an AXI4-Lite register port.
 * Assumes an external memory arbiter and PCI master interface, both on clk.
 */
`timescale 1ns/1ns
module pde_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pde_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [pde_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Memory arbiter side
  output logic mem_req,
  input wire logic mem_gnt,
  input wire logic mem_ack,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_region_one_word,
  // CPU activity
  input wire logic cpu_mem_busy,
  input wire logic cpu_mem_pend,
  input wire logic cpu_pci_pend,
  // PCI master side
  output logic pci_req,
  input wire logic pci_gnt,
  input wire logic pci_ack,
  input wire logic pci_mabort,
  input wire logic pci_tabort,
  output logic pci_we,
  output logic pci_mem_space,
  output logic pci_disc,
  output logic [31:0] pci_addr,
  output logic [31:0] pci_wdata,
  input wire logic [31:0] pci_rdata,
  // CPU interrupt
  input wire logic cpu_int_en,
  output logic cpu_int
);
  import pde_pkg::*;

  typedef struct packed {
    pde_state_t st;
    logic [NCH-1:0][31:0] ctrl;
    logic [NCH-1:0][31:0] maddr;
    logic [NCH-1:0][31:0] paddr;
    logic [31:0] nra;
    logic [PRIO_W-1:0] prio;
    logic [31:0] isr;
    logic [1:0] bes;
    logic [1:0] act;
    logic [31:0] mcur;
    logic [31:0] pcur;
    logic [WORDS_W-1:0] mleft;
    logic [WORDS_W-1:0] pleft;
    logic mem_on;
    logic pci_on;
    logic thr_one;
    logic [1:0] fidx;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic disc;
  } pde_regs_t;

  pde_regs_t s;
  pde_regs_t next_s;
  logic [FIFO_CW-1:0] f_cnt;
  logic f_full;
  logic f_empty;
  logic [31:0] f_head;
  logic f_clr;
  logic f_push;
  logic f_pop;
  logic dir;
  logic xfer;
  logic mem_beat;
  logic pci_beat;
  logic [NCH-1:0] busy;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode: {hit, kind, channel}; kind 0 control, 1 memory, 2 PCI
  function automatic logic [4:0] dec(input logic [ADDR_W-1:0] a);
    logic [4:0] r;
    r = '0;
    for (int c = 0; c < NCH; c++) begin
      if (a == OFF_CTRL[c]) r = {1'b1, 2'h0, 2'(c)};
      if (a == OFF_CTRL[c] + OFF_MADDR_REL) r = {1'b1, 2'h1, 2'(c)};
      if (a == OFF_CTRL[c] + OFF_PADDR_REL) r = {1'b1, 2'h2, 2'(c)};
    end
    return r;
  endfunction : dec

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] m);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Data FIFO
  pde_fifo #(.W(FIFO_W), .D(FIFO_DEPTH), .CW(FIFO_CW)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(f_clr),
    .push(f_push),
    .wdata(dir ? pci_rdata : mem_rdata),
    .pop(f_pop),
    .rdata(f_head),
    .count(f_cnt),
    .full(f_full),
    .empty(f_empty)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Port side
  assign dir = s.ctrl[s.act][B_DIR];
  assign xfer = (s.st == S_XFER);
  for (genvar c = 0; c < NCH; c++) begin : g_busy
    assign busy[c] = (s.st != S_IDLE) && (s.act == 2'(c));
  end
  assign mem_req = (s.st == S_FETCH) ||
                   (xfer && s.mem_on && (dir ? !f_empty : (!f_full && s.mleft != '0)));
  assign pci_req = xfer && s.pci_on && (dir ? (!f_full && s.pleft != '0) : !f_empty);
  assign mem_beat = mem_req && mem_gnt && mem_ack;
  assign pci_beat = pci_req && pci_gnt && pci_ack;
  assign f_push = xfer && (dir ? pci_beat : mem_beat);
  assign f_pop = xfer && (dir ? mem_beat : pci_beat);
  assign mem_we = xfer && dir;
  assign mem_addr = (s.st == S_FETCH) ? s.nra + {28'h0, s.fidx, 2'h0} : s.mcur;
  assign mem_wdata = f_head;
  assign pci_wdata = f_head;
  assign pci_addr = s.pcur;
  assign pci_we = !dir;
  assign pci_mem_space = s.ctrl[s.act][B_MIO];
  assign pci_disc = s.disc;
  assign cpu_int = cpu_int_en && (|s.isr);
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [4:0] d;
    logic [31:0] v;
    logic start;
    logic [1:0] pick;
    logic [WORDS_W-1:0] words;
    d = '0;
    v = '0;
    start = 1'b0;
    pick = '0;
    words = '0;
    next_s = s;
    next_s.disc = 1'b0;
    f_clr = 1'b0;
    // Bus write
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.wd = s_axi_wdata;
      next_s.ws = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      d = dec(s.awa);
      if (d[4]) begin
        v = merge(s.ctrl[d[1:0]], s.wd, s.ws);
        if (d[3:2] == 2'h0 && busy[d[1:0]]) begin
          next_s.ctrl[d[1:0]][B_DRST] = v[B_DRST];
        end else if (d[3:2] == 2'h0) begin
          next_s.ctrl[d[1:0]] = v;
          next_s.ctrl[d[1:0]][B_BUSY] = 1'b0;
          next_s.ctrl[d[1:0]][B_GO] = v[B_GO] | s.ctrl[d[1:0]][B_GO];
        end else if (d[3:2] == 2'h1 && !busy[d[1:0]]) begin
          next_s.maddr[d[1:0]] = merge(s.maddr[d[1:0]], s.wd, s.ws);
        end else if (d[3:2] == 2'h2 && !busy[d[1:0]]) begin
          next_s.paddr[d[1:0]] = merge(s.paddr[d[1:0]], s.wd, s.ws);
        end
      end else if (s.awa == OFF_NRA) begin
        next_s.nra = merge(s.nra, s.wd, s.ws);
      end else if (s.awa == OFF_PRIO) begin
        v = merge({18'h0, s.prio}, s.wd, s.ws);
        next_s.prio = {v[PRIO_W-1:8], 8'h00};
      end else if (s.awa == OFF_ISR) begin
        next_s.isr = s.isr & ~(s.wd & {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}});
      end else if (s.awa == OFF_BES) begin
        next_s.bes = s.bes & ~(s.wd[1:0] & {2{s.ws[0]}});
      end else if (s.awa != OFF_WREM && s.awa != OFF_CMEM && s.awa != OFF_CPCI) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    // Bus read
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (s_axi_arvalid && !s.rvalid) begin
      d = dec(s_axi_araddr);
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      if (d[4] && d[3:2] == 2'h0) begin
        next_s.rdata = s.ctrl[d[1:0]];
        next_s.rdata[B_BUSY] = busy[d[1:0]];
      end else if (d[4] && d[3:2] == 2'h1) begin
        next_s.rdata = s.maddr[d[1:0]];
      end else if (d[4]) begin
        next_s.rdata = s.paddr[d[1:0]];
      end else begin
        case (s_axi_araddr)
          OFF_NRA: next_s.rdata = s.nra;
          OFF_PRIO: next_s.rdata = {18'h0, s.prio[PRIO_W-1:8], 8'h00};
          OFF_ISR: next_s.rdata = s.isr;
          OFF_BES: next_s.rdata = {30'h0, s.bes};
          OFF_WREM: next_s.rdata = {13'h0, s.mleft};
          OFF_CMEM: next_s.rdata = s.mcur;
          OFF_CPCI: next_s.rdata = s.pcur;
          default: next_s.rresp = RESP_SLVERR;
        endcase
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Engine
    case (s.st)
      S_IDLE: begin
        for (int c = NCH - 1; c >= 0; c--) begin
          if (s.ctrl[c][B_GO]) begin
            start = 1'b1;
            pick = 2'(c);
          end
        end
        if (start) next_s.act = pick;
      end
      S_YIELD: begin
        if (!cpu_mem_pend && !cpu_pci_pend) next_s.st = S_IDLE;
      end
      S_FETCH: begin
        if (mem_beat) begin
          next_s.fidx = s.fidx + 1'b1;
          case (s.fidx)
            2'h0: next_s.maddr[s.act] = mem_rdata;
            2'h1: next_s.paddr[s.act] = mem_rdata;
            2'h2: next_s.ctrl[s.act] = {1'b0, mem_rdata[30:29], 1'b1, mem_rdata[27:0]};
            default: begin
              next_s.nra = mem_rdata;
              start = 1'b1;
              pick = s.act;
            end
          endcase
        end
      end
      S_XFER: begin
        if (mem_beat) begin
          next_s.mleft = s.mleft - 1'b1;
          next_s.mcur = s.mcur + 32'h4;
        end
        if (pci_beat) begin
          next_s.pleft = s.pleft - 1'b1;
          if (s.ctrl[s.act][B_INC]) next_s.pcur = s.pcur + 32'h4;
        end
        if (dir) begin
          if (f_full) begin
            next_s.pci_on = 1'b0;
          end else if (!s.pci_on && f_cnt <= HALF_WORDS) begin
            next_s.pci_on = 1'b1;
          end
          if (!s.mem_on && !cpu_mem_busy &&
              (f_cnt >= HALF_WORDS || (s.pleft == '0 && !f_empty))) begin
            next_s.mem_on = 1'b1;
          end else if (mem_beat && f_cnt == 4'h1 && !f_push && s.pleft != '0) begin
            next_s.mem_on = 1'b0;
          end
        end else begin
          if (f_full) begin
            next_s.mem_on = 1'b0;
          end else if (!s.mem_on && !cpu_mem_busy && f_cnt <= HALF_WORDS && s.mleft != '0) begin
            next_s.mem_on = 1'b1;
          end
          if (!s.pci_on && (f_cnt >= (s.thr_one ? 4'h1 : HALF_WORDS) ||
                            (s.mleft == '0 && !f_empty))) begin
            next_s.pci_on = 1'b1;
          end else if (pci_beat && f_cnt == 4'h1 && !f_push && s.pleft != 19'h1) begin
            next_s.pci_on = 1'b0;
            next_s.disc = 1'b1;
            next_s.thr_one = mem_region_one_word;
          end
        end
        if (pci_req && pci_gnt && (pci_mabort || pci_tabort)) begin
          next_s.bes = next_s.bes | {pci_tabort, pci_mabort};
          next_s.isr[B_BERR] = 1'b1;
          next_s.ctrl[s.act][B_GO] = 1'b0;
          next_s.ctrl[s.act][B_DRST] = 1'b0;
          f_clr = 1'b1;
          next_s.st = S_YIELD;
        end else if (s.ctrl[s.act][B_DRST]) begin
          next_s.ctrl[s.act][B_GO] = 1'b0;
          next_s.ctrl[s.act][B_DRST] = 1'b0;
          f_clr = 1'b1;
          next_s.st = S_YIELD;
        end else if (s.pleft == '0 && s.mleft == '0 && f_empty) begin
          if (s.prio[CHAIN_LSB + s.act] && s.nra != '0) begin
            next_s.st = S_FETCH;
            next_s.fidx = '0;
          end else begin
            next_s.ctrl[s.act][B_GO] = 1'b0;
            if (s.ctrl[s.act][B_IE]) next_s.isr[DONE_BIT[s.act]] = 1'b1;
            next_s.st = S_YIELD;
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    if (start) begin
      words = WORDS_W'(next_s.ctrl[pick][B_SIZE_MSB:2]);
      next_s.st = S_XFER;
      next_s.mleft = (words == '0) ? WORDS_1MB : words;
      next_s.pleft = (words == '0) ? WORDS_1MB : words;
      next_s.mcur = next_s.maddr[pick];
      next_s.pcur = next_s.paddr[pick];
      next_s.mem_on = 1'b0;
      next_s.pci_on = next_s.ctrl[pick][B_DIR];
      next_s.thr_one = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.prio <= PRIO_RST;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_p2m_mem_wait: assert property ($rose(s.mem_on) && xfer && dir |->
    $past(f_cnt) >= HALF_WORDS || $past(s.pleft) == '0) else $error("memory taken early");
  a_mem_after_cpu: assert property ($rose(s.mem_on) |-> $past(!cpu_mem_busy))
    else $error("memory taken while CPU busy");
  a_p2m_full_release: assert property (xfer && dir && f_full |-> !pci_req)
    else $error("PCI held with full FIFO");
  a_m2p_full_release: assert property (xfer && !dir && f_full |-> !mem_req)
    else $error("memory held with full FIFO");
  a_m2p_pci_wait: assert property ($rose(s.pci_on) && xfer && !dir && !s.thr_one |->
    $past(f_cnt) >= HALF_WORDS || $past(s.mleft) == '0) else $error("PCI taken early");
  a_disc_empty: assert property (s.disc |-> f_empty && !dir && !s.pci_on)
    else $error("disconnect with data");
  a_mem_stop: assert property (xfer && !dir && s.mleft == '0 |-> !mem_req)
    else $error("memory read beyond amount");
  a_abort_error: assert property (xfer && pci_req && pci_gnt && pci_mabort |=>
    s.bes[0] && s.isr[B_BERR] && s.st == S_YIELD) else $error("abort not recorded");
  a_busy_done: assert property (xfer ##1 s.st == S_YIELD |-> !s.ctrl[s.act][B_GO])
    else $error("start bit left set");

endmodule : pde_engine

// >>> tb/pde_far_end.sv
/*
 * Far side of the DMA engine: memory arbiter and PCI target in one model.
 * Assumes one clock; read data are address patterns, checked in order.
 */
`timescale 1ns/1ns
module pde_far_end (
  // Clock, reset and bench control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic flush,
  // Memory side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_gnt,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // PCI side
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [31:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  input wire logic pci_disc,
  output logic pci_gnt,
  output logic pci_ack,
  output logic [31:0] pci_rdata,
  // Beat and error counters
  output int mem_n,
  output int pci_n,
  output int bad
);
  logic [31:0] q[$];
  logic mgo, pgo;
  logic [31:0] mpat, ppat;
  assign mpat = {8'hA5, mem_addr[23:0]};
  assign ppat = {8'h5A, pci_addr[23:0]};
  assign mem_ack = mem_req && mem_gnt && mgo;
  assign pci_ack = pci_req && pci_gnt && pgo;
  // Inverted data outside a beat
  assign mem_rdata = mem_ack ? mpat : ~mpat;
  assign pci_rdata = pci_ack ? ppat : ~ppat;
  always @(posedge clk) begin
    mgo <= !slow || $urandom_range(1);
    pgo <= !slow || $urandom_range(1);
    if (sys_rst) begin
      {mem_gnt, pci_gnt} <= 2'h0;
      {mem_n, pci_n, bad} <= '0;
      q.delete();
    end else begin
      mem_gnt <= mem_req;
      pci_gnt <= pci_req;
      if (mem_ack) mem_n <= mem_n + 1;
      if (pci_ack) pci_n <= pci_n + 1;
      // Disconnect leaves the PCI request down
      if (pci_disc && pci_req) bad <= bad + 1;
      // Written words must arrive in the order they were read; aborts drop the queue
      if (flush) begin
        q.delete();
      end else begin
        if (mem_ack && mem_we && (q.size() == 0 || q.pop_front() !== mem_wdata)) bad <= bad + 1;
        if (pci_ack && pci_we && (q.size() == 0 || q.pop_front() !== pci_wdata)) bad <= bad + 1;
        if (mem_ack && !mem_we) q.push_back(mpat);
        if (pci_ack && !pci_we) q.push_back(ppat);
      end
    end
  end
endmodule : pde_far_end

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the DMA engine over AXI4-Lite registers.
 * Assumes the far-end model answers memory and PCI traffic.
 */
`timescale 1ns/1ns
module tb_top;
  import pde_pkg::*;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_req, mem_gnt, mem_ack, mem_we, mem_region_one_word, cpu_mem_busy, cpu_mem_pend;
  logic cpu_pci_pend, pci_req, pci_gnt, pci_ack, pci_mabort, pci_tabort, pci_we;
  logic pci_mem_space, pci_disc, cpu_int_en, cpu_int, slow, flush;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] pci_addr, pci_wdata, pci_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mem_n, pci_n, bad, error_cnt, check_count, cyc;
  pde_engine dut (.*);
  pde_far_end u_far (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cpu_mem_busy <= ($urandom_range(7) == 0);
    cpu_mem_pend <= ($urandom_range(7) == 0);
    cpu_pci_pend <= ($urandom_range(7) == 0);
    mem_region_one_word <= $urandom_range(1);
    if (cyc == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  function automatic logic [31:0] ctrl_word(logic dr, int w);
    return {2'b01, dr, 5'b10110, 4'h0, 20'(w * 4)};
  endfunction : ctrl_word
  task automatic prog(int s, logic dr, int w);
    wr(OFF_CTRL[s] + 8'h04, 32'h0001_0000 * (s + 1));
    wr(OFF_CTRL[s] + 8'h08, 32'h0080_0000);
    wr(OFF_CTRL[s], ctrl_word(dr, w));
  endtask : prog
  task automatic finish(int s, int w, int m0, int p0);
    logic [31:0] d;
    logic [1:0] r;
    do rd(OFF_CTRL[s], d, r); while (d[B_BUSY]);
    chk(32'(d[B_GO]), 32'h0);
    chk(32'(mem_n - m0), 32'(w));
    chk(32'(pci_n - p0), 32'(w));
    rd(OFF_ISR, d, r);
    chk(32'(d[DONE_BIT[s]]), 32'h1);
    chk(32'(cpu_int), 32'h1);
    wr(OFF_ISR, 32'h1 << DONE_BIT[s]);
    chk(32'(cpu_int), 32'h0);
  endtask : finish
  task automatic xfer(int s, logic dr, int w);
    int m0 = mem_n;
    int p0 = pci_n;
    logic [31:0] d;
    logic [1:0] r;
    prog(s, dr, w);
    rd(OFF_CTRL[s], d, r);
    chk(32'(d[B_BUSY]), 32'h1);
    wr(OFF_CTRL[s], 32'h0);
    finish(s, w, m0, p0);
  endtask : xfer
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int m0, p0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {pci_mabort, pci_tabort, slow, flush} = '0;
    cpu_int_en = 1'b1;
    void'($urandom(81));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFF_PRIO, d, r);
    chk(d, 32'h0);
    rd(8'hFC, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      slow <= $urandom_range(1);
      xfer(i % 4, $urandom_range(1), 9 + $urandom_range(31));
    end
    slow <= 1'b0;
    // Channel reset while busy: no completion, start bit cleared
    prog(1, 1'b0, 40);
    wr(OFF_CTRL[1], 32'h0100_0000);
    do rd(OFF_CTRL[1], d, r); while (d[B_BUSY]);
    chk(32'(d[B_GO]), 32'h0);
    rd(OFF_ISR, d, r);
    chk(d, 32'h0);
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    for (int ab = 0; ab < 2; ab++) begin
      prog(2, 1'b0, 60);
      prog(3, 1'b1, 12);
      do @(posedge clk); while (!(pci_req && pci_gnt));
      chk(32'(pci_mem_space), 32'h1);
      {pci_mabort, pci_tabort, flush} <= {ab == 0, ab == 1, 1'b1};
      do @(posedge clk); while (pci_req || mem_req);
      {pci_mabort, pci_tabort, flush} <= '0;
      m0 = mem_n;
      p0 = pci_n;
      rd(OFF_BES, d, r);
      chk(d & 32'h3, (ab == 1) ? 32'h2 : 32'h1);
      rd(OFF_ISR, d, r);
      chk(32'(d[B_BERR]), 32'h1);
      chk(32'(cpu_int), 32'h1);
      rd(OFF_CTRL[2], d, r);
      chk(32'(d[B_BUSY] | d[B_GO]), 32'h0);
      wr(OFF_BES, 32'h3);
      wr(OFF_ISR, 32'h0000_0020);
      finish(3, 12, m0, p0);
    end
    chk(32'(bad), 32'h0);
    print_verdict();
  end
endmodule : tb_top
